// *** system_register_unlock.sv ***
`timescale 1ns/100ps
`default_nettype none
module system_register_unlock
  import sysunlock_pkg::*;
#(
  parameter logic [31:0] DEVICE_ID = DEVICE_ID_DEFAULT
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [ADDR_WIDTH-1:0] addr,
  input wire logic [31:0] wr_data,
  output logic [31:0] rd_data,
  output logic unlocked,
  output logic [BOUNDARY_WIDTH-1:0] ram_exec_boundary,
  output logic [31:0] exec_base_offset,
  output logic [31:0] protected_value
);
  localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;

  // Local state: boundary field, protected sample and read data; the lock state is in u_seq
  typedef struct packed {
    logic [BOUNDARY_WIDTH-1:0] boundary;
    logic [31:0] prot;
    logic [31:0] rdata;
  } regs_s;

  // Shared decode of one offset on the register address
  function automatic logic addr_is(
    input logic [ADDR_WIDTH-1:0] a,
    input logic [ADDR_WIDTH-1:0] offset
  );
    return (a == offset);
  endfunction

  // Boundary field widened to a data word
  function automatic logic [31:0] boundary_word(
    input logic [BOUNDARY_WIDTH-1:0] b
  );
    logic [31:0] w;
    w = RDATA_IDLE;
    w[BOUNDARY_WIDTH-1:0] = b;
    return w;
  endfunction

  // Byte offset of the boundary, one step per count
  function automatic logic [31:0] boundary_bytes(
    input logic [BOUNDARY_WIDTH-1:0] b
  );
    logic [31:0] w;
    w = boundary_word(b);
    w = w << BOUNDARY_SHIFT;
    return w;
  endfunction

  // Key register readback
  function automatic logic [31:0] key_word(
    input logic open
  );
    logic [31:0] w;
    w = RDATA_IDLE;
    if (open) begin
      w = UNLOCKED_READ_VALUE;
    end
    return w;
  endfunction

  // Read mux; unmapped offsets read zero
  function automatic logic [31:0] read_word(
    input logic [ADDR_WIDTH-1:0] a,
    input logic open,
    input logic [BOUNDARY_WIDTH-1:0] b,
    input logic [31:0] p
  );
    logic [31:0] w;
    w = RDATA_IDLE;
    unique case (a)
      KEY_OFFSET: begin
        w = key_word(open);
      end
      CONFIG_OFFSET: begin
        w = boundary_word(b);
      end
      IDENTITY_OFFSET: begin
        w = DEVICE_ID;
      end
      PROT_OFFSET: begin
        w = p;
      end
      default: begin
        w = RDATA_IDLE;
      end
    endcase
    return w;
  endfunction

  // Next boundary: only a gated write moves it
  function automatic logic [BOUNDARY_WIDTH-1:0] next_boundary(
    input logic [BOUNDARY_WIDTH-1:0] cur,
    input logic wr_ok,
    input logic [31:0] d
  );
    logic [BOUNDARY_WIDTH-1:0] n;
    n = cur;
    if (wr_ok) begin
      n = d[BOUNDARY_WIDTH-1:0];
    end
    return n;
  endfunction

  // Next protected word: only a gated write changes it
  function automatic logic [31:0] next_prot(
    input logic [31:0] cur,
    input logic wr_ok,
    input logic [31:0] d
  );
    logic [31:0] n;
    n = cur;
    if (wr_ok) begin
      n = d;
    end
    return n;
  endfunction

  // Read data stands one cycle, zero otherwise
  function automatic logic [31:0] next_rdata(
    input logic rd,
    input logic [31:0] word
  );
    logic [31:0] n;
    n = RDATA_IDLE;
    if (rd) begin
      n = word;
    end
    return n;
  endfunction

  regs_s regs_r;
  regs_s regs_nxt;
  logic key_hit;
  logic cfg_hit;
  logic prot_hit;
  logic cfg_wr_ok;
  logic prot_wr_ok;
  logic [31:0] rd_word;

  // Offset decode
  assign key_hit = addr_is(addr, KEY_OFFSET);
  assign cfg_hit = addr_is(addr, CONFIG_OFFSET);
  assign prot_hit = addr_is(addr, PROT_OFFSET);

  assign cfg_wr_ok = wr_en && unlocked && cfg_hit;
  assign prot_wr_ok = wr_en && unlocked && prot_hit;
  // Identity offset has no write path: it is read-only

  // Read and write may share a cycle; the read returns the old contents
  assign rd_word = read_word(
    addr,
    unlocked,
    regs_r.boundary,
    regs_r.prot
  );

  // Sequencer sees every write, so foreign writes abort a half unlock
  key_sequencer u_seq (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(wr_en),
    .key_hit(key_hit),
    .wr_data(wr_data),
    .unlocked(unlocked)
  );

  always_comb begin
    regs_nxt = regs_r;
    regs_nxt.boundary = next_boundary(regs_r.boundary, cfg_wr_ok, wr_data);
    regs_nxt.prot = next_prot(regs_r.prot, prot_wr_ok, wr_data);
    regs_nxt.rdata = next_rdata(rd_en, rd_word);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      regs_r <= '{
        boundary: BOUNDARY_RESET,
        prot: PROT_RESET,
        rdata: RDATA_IDLE
      };
    end else begin
      regs_r <= regs_nxt;
    end
  end

  assign rd_data = regs_r.rdata;
  assign ram_exec_boundary = regs_r.boundary;
  assign exec_base_offset = boundary_bytes(regs_r.boundary);
  assign protected_value = regs_r.prot;
endmodule
`default_nettype wire

// *** sysunlock_pkg.sv ***
package sysunlock_pkg;
  localparam logic [31:0] KEY_FIRST = 32'haa996655;
  localparam logic [31:0] KEY_SECOND = 32'h556699aa;
  localparam logic [31:0] UNLOCKED_READ_VALUE = 32'h0000_0001;
  // Identity code: arbitrary value, not tied to any real part
  localparam logic [31:0] DEVICE_ID_DEFAULT = 32'h1234_5a5a;
  localparam int BOUNDARY_WIDTH = 8;
  localparam int BOUNDARY_STEP_BYTES = 1024;
  localparam int BOUNDARY_SHIFT = 10;
  localparam logic [7:0] BOUNDARY_RESET = 8'h00;
  localparam int ADDR_WIDTH = 8;
  localparam logic [7:0] KEY_OFFSET = 8'h00;
  localparam logic [7:0] CONFIG_OFFSET = 8'h04;
  localparam logic [7:0] IDENTITY_OFFSET = 8'h08;
  localparam logic [7:0] PROT_OFFSET = 8'h0c;
  localparam logic [31:0] PROT_RESET = 32'h0000_0000;
  typedef enum logic [1:0] {
    LK_LOCKED = 2'b00,
    LK_HALF = 2'b01,
    LK_OPEN = 2'b11
  } lock_state_e;
endpackage

// *** key_sequencer.sv ***
`timescale 1ns/100ps
`default_nettype none
module key_sequencer
  import sysunlock_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic key_hit,
  input wire logic [31:0] wr_data,
  output logic unlocked
);
  typedef struct packed {
    lock_state_e st;
  } seq_s;

  seq_s state_r;
  seq_s state_nxt;

  always_comb begin
    state_nxt = state_r;
    if (wr_en && key_hit) begin
      unique case (state_r.st)
        LK_LOCKED: begin
          state_nxt.st = (wr_data == KEY_FIRST) ? LK_HALF : LK_LOCKED;
        end
        LK_HALF: begin
          if (wr_data == KEY_SECOND) begin
            state_nxt.st = LK_OPEN;
          end else if (wr_data == KEY_FIRST) begin
            state_nxt.st = LK_HALF;
          end else begin
            state_nxt.st = LK_LOCKED;
          end
        end
        LK_OPEN: begin
          if (wr_data != KEY_FIRST && wr_data != KEY_SECOND) begin
            state_nxt.st = LK_LOCKED;
          end
        end
        default: state_nxt.st = LK_LOCKED;
      endcase
    end else if (wr_en && state_r.st == LK_HALF) begin
      state_nxt.st = LK_LOCKED;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= '{st: LK_LOCKED};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign unlocked = (state_r.st == LK_OPEN);
endmodule
`default_nettype wire

// *** sru_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
module sru_checker
  import sysunlock_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic unlocked,
  input wire logic [7:0] addr,
  input wire logic [7:0] ram_exec_boundary,
  input wire logic [31:0] wr_data,
  input wire logic [31:0] rd_data,
  input wire logic [31:0] exec_base_offset,
  input wire logic [31:0] protected_value
);
  default clocking @(posedge core_clk);endclocking
  default disable iff(rst);
  wire kw=wr_en&&addr==KEY_OFFSET;
  sequence s_k1;kw&&wr_data==KEY_FIRST;endsequence
  sequence s_k2;kw&&wr_data==KEY_SECOND;endsequence
  property p_lk;!unlocked&&wr_en&&addr==PROT_OFFSET|=>$stable(protected_value);endproperty
  a_lk:assert property(p_lk)else $error("lk");
  property p_op;s_k1 ##1 s_k2|=>unlocked;endproperty
  a_op:assert property(p_op)else $error("op");
  property p_rl;unlocked&&kw&&wr_data!=KEY_FIRST&&wr_data!=KEY_SECOND|=>!unlocked;endproperty
  a_rl:assert property(p_rl)else $error("rl");
  property p_ab;!unlocked ##0 s_k1 ##1 wr_en&&!kw ##1 s_k2|=>!unlocked;endproperty
  a_ab:assert property(p_ab)else $error("ab");
  property p_rd;rd_en&&addr==KEY_OFFSET|=>(rd_data!=0)==$past(unlocked);endproperty
  a_rd:assert property(p_rd)else $error("rd");
  property p_bd;unlocked&&wr_en&&addr==CONFIG_OFFSET|=>ram_exec_boundary==8'($past(wr_data));
  endproperty
  a_bd:assert property(p_bd)else $error("bd");
  property p_ex;exec_base_offset=={ram_exec_boundary,10'h000};endproperty
  a_ex:assert property(p_ex)else $error("ex");
  property p_id;rd_en&&addr==IDENTITY_OFFSET|=>rd_data==DEVICE_ID_DEFAULT;endproperty
  a_id:assert property(p_id)else $error("id");
  property p_rs;$fell(rst)|->!unlocked&&protected_value==PROT_RESET&&ram_exec_boundary==BOUNDARY_RESET;
  endproperty
  a_rs:assert property(p_rs)else $error("rs");
endmodule
bind system_register_unlock sru_checker i_chk(
  .core_clk(core_clk),
  .rst(rst),
  .wr_en(wr_en),
  .rd_en(rd_en),
  .unlocked(unlocked),
  .addr(addr),
  .ram_exec_boundary(ram_exec_boundary),
  .wr_data(wr_data),
  .rd_data(rd_data),
  .exec_base_offset(exec_base_offset),
  .protected_value(protected_value)
);
`default_nettype wire

// *** system_register_unlock_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module system_register_unlock_tb import sysunlock_pkg::*;;
`define C(g,e) begin total_checks++;if((g)!==(e))begin fail_count++;\
$display("[ERR] %0t bad",$time);end end
  logic core_clk=0,rst=1,wr_en=0,rd_en=0,rv=0,unlocked;
  logic [7:0] addr=0,ram_exec_boundary;
  logic [31:0] wr_data=0,rd_data,exec_base_offset,protected_value,r,q[$];
  int fail_count=0,total_checks=0;
  system_register_unlock i_dut(
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .addr(addr),
    .wr_data(wr_data),
    .rd_data(rd_data),
    .unlocked(unlocked),
    .ram_exec_boundary(ram_exec_boundary),
    .exec_base_offset(exec_base_offset),
    .protected_value(protected_value)
  );
  always #20 core_clk=~core_clk;
  always @(posedge core_clk) rv<=rd_en;
  always @(posedge core_clk) if(rv) `C(rd_data,q.pop_front())
  task automatic op(logic w,v,logic [7:0] a,logic [31:0] d);
    {wr_en,rd_en,addr,wr_data}={w,v,a,d};
    @(posedge core_clk) #1;
  endtask
  task automatic rk(logic [7:0] a,logic [31:0] e);
    q.push_back(e);
    op(1'b0,1'b1,a,32'h0000_0000);
  endtask
  task print_verdict;
    $display("%0d fails %0d checks",fail_count,total_checks);
    if(fail_count==0&&total_checks>0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #8000 fail_count++;
    print_verdict;
  end
  initial begin
    void'($urandom(90));
    repeat(20) @(posedge core_clk);
    #1 rst=0;
    r=$urandom|32'h0000_0001;
    rk(KEY_OFFSET,32'h0000_0000);
    rk(IDENTITY_OFFSET,DEVICE_ID_DEFAULT);
    op(1'b1,1'b0,CONFIG_OFFSET,r);
    rk(CONFIG_OFFSET,32'h0000_0000);
    op(1'b1,1'b0,KEY_OFFSET,32'h0000_0000);
    op(1'b1,1'b0,KEY_OFFSET,KEY_FIRST);
    op(1'b1,1'b0,PROT_OFFSET,r);
    op(1'b1,1'b0,KEY_OFFSET,KEY_SECOND);
    op(1'b1,1'b0,KEY_OFFSET,KEY_FIRST);
    `C(unlocked,1'b0)
    op(1'b1,1'b0,KEY_OFFSET,KEY_SECOND);
    `C(unlocked,1'b1)
    rk(KEY_OFFSET,UNLOCKED_READ_VALUE);
    op(1'b1,1'b0,KEY_OFFSET,KEY_FIRST);
    `C(unlocked,1'b1)
    op(1'b1,1'b0,PROT_OFFSET,r);
    op(1'b1,1'b0,CONFIG_OFFSET,r);
    `C(ram_exec_boundary,r[7:0])
    `C(exec_base_offset,{14'h0000,r[7:0],10'h000})
    rk(PROT_OFFSET,r);
    rk(CONFIG_OFFSET,{24'h000000,r[7:0]});
    op(1'b1,1'b0,KEY_OFFSET,32'h0000_0000);
    op(1'b1,1'b0,PROT_OFFSET,~r);
    `C(protected_value,r)
    `C(unlocked,1'b0)
    op(1'b1,1'b0,KEY_OFFSET,KEY_FIRST);
    op(1'b1,1'b0,KEY_OFFSET,KEY_SECOND);
    op(1'b0,1'b0,KEY_OFFSET,32'h0000_0000);
    rst=1'b1;
    repeat(2) @(posedge core_clk);
    #1 rst=1'b0;
    `C(unlocked,1'b0)
    `C(protected_value,PROT_RESET)
    rk(KEY_OFFSET,32'h0000_0000);
    op(1'b0,1'b0,KEY_OFFSET,32'h0000_0000);
    print_verdict;
  end
endmodule
`default_nettype wire
